// File: hw/wac_pkg.sv
// Package of constants for the wiper advanced control block
package wac_pkg;
    localparam int WAC_W = 8;
    localparam int WAC_CH = 2;
    // Two registers per channel: index 0 wiper/upper, 1 lower string
    localparam int WAC_SLOTS = 2 * WAC_CH;
    localparam logic [7:0] WAC_MID = 8'h80;
    localparam logic [7:0] WAC_FULL = 8'hFF;
    localparam logic [7:0] WAC_ZERO = 8'h00;
    localparam logic [7:0] WAC_ONE = 8'h01;
    // Command codes
    localparam logic [4:0] CMD_NOP = 5'h00;
    localparam logic [4:0] CMD_WR_WIPER = 5'h01;
    localparam logic [4:0] CMD_WR_PRELOAD = 5'h02;
    localparam logic [4:0] CMD_INC = 5'h04;
    localparam logic [4:0] CMD_DEC = 5'h05;
    localparam logic [4:0] CMD_DBL = 5'h06;
    localparam logic [4:0] CMD_HALF = 5'h07;
    localparam logic [4:0] CMD_LOAD_PRE = 5'h08;
    localparam logic [4:0] CMD_SAVE_NV = 5'h09;
    localparam logic [4:0] CMD_RESTORE_NV = 5'h0A;
    localparam logic [4:0] CMD_WR_NV = 5'h0B;
    localparam logic [4:0] CMD_TOP = 5'h0C;
    localparam logic [4:0] CMD_BOTTOM = 5'h0D;
    localparam logic [4:0] CMD_RESET = 5'h0E;
    localparam logic [4:0] CMD_SHUT = 5'h0F;
    localparam logic [4:0] CMD_CTRL = 5'h10;
    // Control register bits
    localparam int CTRL_NV_PROT = 0;
    localparam int CTRL_WIPER_PROT = 1;
    localparam int CTRL_GAIN = 2;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    // Address fields: bit 3 all channels, bit 2 lower string, bit 0 ch
    localparam int ADR_ALL = 3;
    localparam int ADR_LOWER = 2;
    localparam int ADR_CH = 0;
    // Reload time
    localparam int RELOAD_NS = 30000;
    localparam int CLK_NS = 10;
    localparam int RELOAD_CYC = RELOAD_NS / CLK_NS;
    typedef enum logic [1:0] {
        WAC_IDLE = 2'b00,
        WAC_RELOAD = 2'b01,
        WAC_DONE = 2'b11
    } wac_state_t;
    typedef enum logic [1:0] {
        WAC_END_NONE = 2'b00,
        WAC_END_TOP = 2'b01,
        WAC_END_BOTTOM = 2'b10
    } wac_end_t;
endpackage

// File: hw/wac_step.sv
// Step arithmetic applied to one wiper value
`timescale 1ns/100ps
module wac_step
    import wac_pkg::*;
(
    // Operation
    input wire logic [4:0] cmd,
    input wire logic [WAC_W-1:0] val,
    // Result
    output logic [WAC_W-1:0] res
);
    always_comb begin
        case (cmd)
            CMD_INC: res = (val == WAC_FULL) ? val : val + WAC_ONE;
            CMD_DEC: res = (val == WAC_ZERO) ? val : val - WAC_ONE;
            CMD_DBL: begin
                if (val == WAC_ZERO)
                    res = WAC_ONE;
                else if (val[WAC_W-1])
                    res = WAC_FULL;
                else
                    res = {val[WAC_W-2:0], 1'b0};
            end
            CMD_HALF: res = {1'b0, val[WAC_W-1:1]};
            default: res = val;
        endcase
    end
endmodule // wac_step

// File: hw/wac_timer.sv
// Reload wait counter
`timescale 1ns/100ps
module wac_timer
    import wac_pkg::*;
#(
    parameter int CYCLES = RELOAD_CYC
)(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Control
    input wire logic start,
    output logic done
);
    logic [15:0] cnt_q;
    logic run_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 16'h0000;
            run_q <= 1'b0;
        end else if (start) begin
            cnt_q <= 16'(CYCLES - 1);
            run_q <= 1'b1;
        end else if (run_q) begin
            if (cnt_q == 16'h0000)
                run_q <= 1'b0;
            else
                cnt_q <= cnt_q - 16'h0001;
        end
    end
    assign done = run_q && (cnt_q == 16'h0000);
endmodule // wac_timer

// File: hw/wac_core.sv
// Command execution for the wiper, preload and stored registers
`timescale 1ns/100ps
module wac_core
    import wac_pkg::*;
#(
    parameter int RELOAD_CYCLES = RELOAD_CYC
)(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Pins
    input wire logic gain_mode_strap_pin,
    input wire logic reset_pin_n,
    // Command strobe from the serial front end
    input wire logic cmd_valid,
    input wire logic [4:0] cmd_code,
    input wire logic [3:0] cmd_addr,
    input wire logic [7:0] cmd_data,
    // Status
    output logic busy_q,
    output logic gain_mode_q,
    output logic shutdown_q,
    output logic [2:0] ctrl_q,
    output logic [1:0] end_pos0_q,
    output logic [1:0] end_pos1_q,
    // Wiper values, slot = channel*2 + lower
    output logic [WAC_SLOTS*WAC_W-1:0] wiper_q,
    output logic [WAC_SLOTS*WAC_W-1:0] preload_q,
    output logic [WAC_SLOTS*WAC_W-1:0] nv_q
);
    // ==========================================================
    // Synchronisers and strap capture
    logic [1:0] strap_s_q;
    logic [1:0] rpin_s_q;
    logic rpin_d1_q;
    logic [1:0] boot_cnt_q;
    logic boot_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_s_q <= 2'b00;
            rpin_s_q <= 2'b11;
            rpin_d1_q <= 1'b1;
        end else begin
            strap_s_q <= {strap_s_q[0], gain_mode_strap_pin};
            rpin_s_q <= {rpin_s_q[0], reset_pin_n};
            rpin_d1_q <= rpin_s_q[1];
        end
    end
    wire pin_reset = rpin_d1_q && !rpin_s_q[1];
    // Boot waits out the strap synchroniser, so the first load and the
    // mode already see the pin level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            boot_cnt_q <= 2'h0;
            boot_q <= 1'b1;
        end else if (boot_q) begin
            boot_cnt_q <= boot_cnt_q + 2'h1;
            boot_q <= boot_cnt_q != 2'h2;
        end
    end
    // ==========================================================
    // Decode
    function automatic logic hit(input logic [3:0] a, input int slot);
        logic ch;
        logic lo;
        ch = slot[1];
        lo = slot[0];
        hit = (a[ADR_ALL] || a[ADR_CH] == ch) && a[ADR_LOWER] == lo;
    endfunction
    wire go = cmd_valid && !busy_q;
    wire wp = ctrl_q[CTRL_WIPER_PROT];
    wire reload = (go && cmd_code == CMD_RESET) || pin_reset;
    wire is_step = cmd_code inside {CMD_INC, CMD_DEC, CMD_DBL, CMD_HALF};
    // ==========================================================
    // Reload sequencer
    wac_state_t st_q;
    logic tmr_done;
    wac_timer #(.CYCLES(RELOAD_CYCLES)) u_timer (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(st_q == WAC_IDLE && reload),
        .done(tmr_done)
    );
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= WAC_IDLE;
        end else begin
            case (st_q)
                WAC_IDLE: if (reload) st_q <= WAC_RELOAD;
                WAC_RELOAD: if (tmr_done) st_q <= WAC_DONE;
                WAC_DONE: st_q <= WAC_IDLE;
                default: st_q <= WAC_IDLE;
            endcase
        end
    end
    // Busy holds off commands through boot and its power-up load, and while a reload runs
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            busy_q <= 1'b1;
        else
            busy_q <= boot_q || reload || st_q == WAC_RELOAD;
    end
    logic boot_d1_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            boot_d1_q <= 1'b1;
        else
            boot_d1_q <= boot_q;
    end
    wire nv_load = st_q == WAC_DONE || (boot_d1_q && !boot_q);
    // ==========================================================
    // Control register and mode
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            ctrl_q <= CTRL_RESET;
        else if (go && cmd_code == CMD_CTRL)
            ctrl_q <= cmd_data[2:0];
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            gain_mode_q <= 1'b0;
        else
            gain_mode_q <= strap_s_q[1] || ctrl_q[CTRL_GAIN];
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst)
            shutdown_q <= 1'b0;
        else if (go && cmd_code == CMD_SHUT)
            shutdown_q <= cmd_data[0];
    end
    // ==========================================================
    // Register array, all four slots exist in both modes
    logic [WAC_W-1:0] step_res [WAC_SLOTS];
    logic [WAC_SLOTS-1:0] loaded;
    genvar g;
    generate
        for (g = 0; g < WAC_SLOTS; g++) begin : g_slot
            wire [WAC_W-1:0] cur = wiper_q[g*WAC_W +: WAC_W];
            wire sel = go && hit(cmd_addr, g);
            wac_step u_step (
                .cmd(cmd_code),
                .val(cur),
                .res(step_res[g])
            );
            // Wiper: protected except memory copy
            assign loaded[g] = nv_load
                || (sel && cmd_code == CMD_RESTORE_NV)
                || (sel && !wp && (is_step
                    || cmd_code == CMD_WR_WIPER
                    || cmd_code == CMD_LOAD_PRE));
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    wiper_q[g*WAC_W +: WAC_W] <= WAC_MID;
                end else if (nv_load
                        || (sel && cmd_code == CMD_RESTORE_NV)) begin
                    wiper_q[g*WAC_W +: WAC_W] <= nv_q[g*WAC_W +: WAC_W];
                end else if (loaded[g]) begin
                    case (cmd_code)
                        CMD_WR_WIPER:
                            wiper_q[g*WAC_W +: WAC_W] <= cmd_data;
                        CMD_LOAD_PRE:
                            wiper_q[g*WAC_W +: WAC_W] <=
                                preload_q[g*WAC_W +: WAC_W];
                        default:
                            wiper_q[g*WAC_W +: WAC_W] <= step_res[g];
                    endcase
                end
            end
            // Preload follows any wiper load
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    preload_q[g*WAC_W +: WAC_W] <= WAC_MID;
                end else if (sel && cmd_code == CMD_WR_PRELOAD) begin
                    preload_q[g*WAC_W +: WAC_W] <= cmd_data;
                end else if (nv_load
                        || (sel && cmd_code == CMD_RESTORE_NV)) begin
                    preload_q[g*WAC_W +: WAC_W] <=
                        nv_q[g*WAC_W +: WAC_W];
                end else if (loaded[g]) begin
                    case (cmd_code)
                        CMD_WR_WIPER:
                            preload_q[g*WAC_W +: WAC_W] <= cmd_data;
                        CMD_LOAD_PRE:
                            preload_q[g*WAC_W +: WAC_W] <=
                                preload_q[g*WAC_W +: WAC_W];
                        default:
                            preload_q[g*WAC_W +: WAC_W] <= step_res[g];
                    endcase
                end
            end
            // Stored values, guarded by control bit D0
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    nv_q[g*WAC_W +: WAC_W] <= WAC_MID;
                end else if (sel && !ctrl_q[CTRL_NV_PROT]) begin
                    if (cmd_code == CMD_SAVE_NV)
                        nv_q[g*WAC_W +: WAC_W] <= cur;
                    else if (cmd_code == CMD_WR_NV)
                        nv_q[g*WAC_W +: WAC_W] <= cmd_data;
                end
            end
        end
    endgenerate
    // ==========================================================
    // End positions, wiper contents untouched
    function automatic logic [1:0] end_next(input logic [1:0] cur,
                                            input int ch);
        logic [1:0] n;
        logic s;
        n = cur;
        s = go && (cmd_addr[ADR_ALL] || cmd_addr[ADR_CH] == ch[0]);
        if (loaded[ch*2] || loaded[ch*2+1]
                || (s && cmd_code == CMD_SHUT && cmd_data[0]))
            n = WAC_END_NONE;
        else if (s && cmd_code == CMD_TOP)
            n = cmd_data[0] ? WAC_END_TOP : WAC_END_NONE;
        else if (s && cmd_code == CMD_BOTTOM)
            n = cmd_data[0] ? WAC_END_BOTTOM : WAC_END_NONE;
        end_next = n;
    endfunction
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            end_pos0_q <= WAC_END_NONE;
            end_pos1_q <= WAC_END_NONE;
        end else begin
            end_pos0_q <= end_next(end_pos0_q, 0);
            end_pos1_q <= end_next(end_pos1_q, 1);
        end
    end
    // ==========================================================
    // Checks
    sequence s_shut_cmd;
        go && cmd_code == CMD_SHUT;
    endsequence
    a_shut_follows: assert property (@(posedge ref_clk) disable iff (rst)
        s_shut_cmd |=> shutdown_q == $past(cmd_data[0]))
        else $error("shutdown state does not follow command");
    a_prot_hold: assert property (@(posedge ref_clk) disable iff (rst)
        go && wp && cmd_code == CMD_WR_WIPER && !nv_load
        |=> $stable(wiper_q))
        else $error("protected wiper changed");
    a_inc_sat: assert property (@(posedge ref_clk) disable iff (rst)
        go && !wp && cmd_code == CMD_INC && hit(cmd_addr, 0)
        && wiper_q[7:0] == WAC_FULL && !nv_load
        |=> wiper_q[7:0] == WAC_FULL)
        else $error("increment wrapped");
    a_dbl_sat: assert property (@(posedge ref_clk) disable iff (rst)
        go && !wp && cmd_code == CMD_DBL && hit(cmd_addr, 0)
        && wiper_q[7] && !nv_load |=> wiper_q[7:0] == WAC_FULL)
        else $error("doubling overflowed");
    a_half_fill: assert property (@(posedge ref_clk) disable iff (rst)
        go && !wp && cmd_code == CMD_HALF && hit(cmd_addr, 0) && !nv_load
        |=> wiper_q[7] == 1'b0)
        else $error("halving did not zero fill");
    a_pre_follow: assert property (@(posedge ref_clk) disable iff (rst)
        go && !wp && cmd_code == CMD_WR_WIPER && hit(cmd_addr, 0)
        && !nv_load |=> preload_q[7:0] == wiper_q[7:0])
        else $error("preload not overwritten");
    a_mode_or: assert property (@(posedge ref_clk) disable iff (rst)
        ##1 gain_mode_q == ($past(strap_s_q[1]) || $past(ctrl_q[CTRL_GAIN])))
        else $error("mode is not strap or control bit");
    a_nv_prot: assert property (@(posedge ref_clk) disable iff (rst)
        ctrl_q[CTRL_NV_PROT] |=> $stable(nv_q))
        else $error("protected memory changed");
    a_reload_busy: assert property (@(posedge ref_clk) disable iff (rst)
        go && cmd_code == CMD_RESET |=> busy_q [*8])
        else $error("reload did not hold busy");
endmodule // wac_core

// File: test/wac_host.sv
// Host model that issues commands to the wiper control block
`timescale 1ns/100ps
module wac_host
    import wac_pkg::*;
(
    // Clock and status
    input wire logic ref_clk,
    input wire logic busy_q,
    // Command strobe
    output logic cmd_valid,
    output logic [4:0] cmd_code,
    output logic [3:0] cmd_addr,
    output logic [7:0] cmd_data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code = CMD_NOP;
        cmd_addr = 4'h0;
        cmd_data = 8'h00;
    end

    // ==========================================================
    // Command issue
    // Holds off while busy, since the block drops commands then
    task automatic send(input logic [4:0] c, input logic [3:0] a,
        input logic [7:0] d);
        int n;
        n = 0;
        while (busy_q !== 1'b0 && n < 500) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        @(posedge ref_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_addr = a;
        cmd_data = d;
        @(posedge ref_clk);
        #1;
        // Idle lines show junk, not the last command
        cmd_valid = 1'b0;
        cmd_code = ~c;
        cmd_addr = ~a;
        cmd_data = ~d;
        @(posedge ref_clk);
        #1;
    endtask
endmodule // wac_host

// File: test/tb.sv
// Self-checking bench for the wiper advanced control block
`timescale 1ns/100ps
module tb import wac_pkg::*;;
    typedef struct packed {
        logic [31:0] w;
        logic [31:0] p;
        logic [31:0] nv;
        logic [7:0] st;
    } wac_exp_t;
    localparam int RC = 8;
    logic ref_clk, rst, gain_mode_strap_pin, reset_pin_n, busy_q;
    logic gain_mode_q, shutdown_q, cmd_valid;
    logic [4:0] cmd_code;
    logic [3:0] cmd_addr;
    logic [7:0] cmd_data;
    logic [2:0] ctrl_q, ct;
    logic [1:0] end_pos0_q, end_pos1_q;
    logic [31:0] wiper_q, preload_q, nv_q;
    logic [7:0] w [4], p [4], nv [4];
    logic [1:0] e [2];
    logic sd;
    int seed = 32'h181d1da0;
    int n_errors = 0;
    int checks = 0;
    wac_exp_t q [$];
    event res_ev;

    wac_core #(.RELOAD_CYCLES(RC)) dut_u (.ref_clk, .rst,
        .gain_mode_strap_pin, .reset_pin_n, .cmd_valid, .cmd_code,
        .cmd_addr, .cmd_data, .busy_q, .gain_mode_q, .shutdown_q,
        .ctrl_q, .end_pos0_q, .end_pos1_q, .wiper_q, .preload_q, .nv_q);
    wac_host host_u (.ref_clk, .busy_q, .cmd_valid, .cmd_code,
        .cmd_addr, .cmd_data);

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ==========================================================
    // Compare and report
    task automatic cmp32(input string n, input logic [31:0] x, a);
        checks++;
        if (a !== x) begin
            n_errors++;
            $display("BAD %0t %s exp %h got %h", $time, n, x, a);
        end
    endtask
    task automatic cmp8(input string n, input logic [7:0] x, a);
        checks++;
        if (a !== x) begin
            n_errors++;
            $display("BAD %0t %s exp %h got %h", $time, n, x, a);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin : watch
        wac_exp_t x;
        forever begin
            @(res_ev);
            x = q.pop_front();
            cmp32("wiper", x.w, wiper_q);
            cmp32("preload", x.p, preload_q);
            cmp32("stored", x.nv, nv_q);
            cmp8("status", x.st, {shutdown_q, ctrl_q, end_pos1_q,
                end_pos0_q});
        end
    end

    // ==========================================================
    // Reference model
    task automatic note();
        q.push_back('{{w[3], w[2], w[1], w[0]}, {p[3], p[2], p[1], p[0]},
            {nv[3], nv[2], nv[1], nv[0]}, {sd, ct, e[1], e[0]}});
        -> res_ev;
    endtask
    task automatic reload(input int mn);
        int n;
        n = 0;
        while (busy_q !== 1'b0 && n < 200) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cmp8("reload", 8'(n >= mn && busy_q === 1'b0), 8'h01);
        w = nv;
        p = nv;
        e = '{2'b00, 2'b00};
    endtask
    task automatic cmd(input logic [4:0] c, input logic [3:0] a,
        input logic [7:0] d);
        int s;
        logic [7:0] v;
        host_u.send(c, a, d);
        for (int k = 0; k < 2; k++) begin
            if (a[3] || a[0] == k[0]) begin
                s = k * 2 + a[2];
                v = w[s];
                case (c)
                    CMD_WR_WIPER: v = d;
                    CMD_INC: v = (v == 8'hFF) ? v : v + 8'h01;
                    CMD_DEC: v = (v == 8'h00) ? v : v - 8'h01;
                    CMD_DBL: v = (v == 8'h00) ? 8'h01
                        : (v[7] ? 8'hFF : v << 1);
                    CMD_HALF: v = v >> 1;
                    CMD_LOAD_PRE: v = p[s];
                    CMD_RESTORE_NV: v = nv[s];
                    CMD_SAVE_NV: if (!ct[0]) nv[s] = w[s];
                    CMD_WR_PRELOAD: p[s] = d;
                    CMD_TOP: e[k] = d[0] ? 2'b01 : 2'b00;
                    CMD_BOTTOM: e[k] = d[0] ? 2'b10 : 2'b00;
                    CMD_SHUT: if (d[0]) e[k] = 2'b00;
                    default: ;
                endcase
                if ((c inside {CMD_WR_WIPER, CMD_INC, CMD_DEC, CMD_DBL,
                    CMD_HALF, CMD_LOAD_PRE} && !ct[1])
                    || c == CMD_RESTORE_NV) begin
                    w[s] = v;
                    p[s] = v;
                    e[k] = 2'b00;
                end
            end
        end
        if (c == CMD_SHUT) sd = d[0];
        if (c == CMD_CTRL) ct = d[2:0];
        if (c == CMD_RESET) reload(RC - 2);
        note();
    endtask
    task automatic boot(input logic s);
        @(posedge ref_clk);
        #1;
        rst = 1'b1;
        gain_mode_strap_pin = s;
        repeat (8) @(posedge ref_clk);
        #1;
        rst = 1'b0;
        nv = '{4{8'h80}};
        ct = 3'h0;
        sd = 1'b0;
        reload(0);
        note();
        cmp8("gain", {7'h0, gain_mode_q}, {7'h0, s});
        $display("test boot done");
    endtask

    // ==========================================================
    // Scenarios
    logic [16:0] seq [] = '{
        {CMD_WR_WIPER, 4'h0, 8'hFE}, {CMD_INC, 4'h0, 8'h01},
        {CMD_INC, 4'h0, 8'h01}, {CMD_WR_WIPER, 4'h1, 8'h01},
        {CMD_DEC, 4'h8, 8'h00}, {CMD_DEC, 4'h8, 8'h00},
        {CMD_WR_PRELOAD, 4'h0, 8'h3C}, {CMD_WR_PRELOAD, 4'h1, 8'hC3},
        {CMD_LOAD_PRE, 4'h8, 8'h00}, {CMD_TOP, 4'h0, 8'h81},
        {CMD_BOTTOM, 4'h1, 8'h81}, {CMD_INC, 4'h0, 8'h01},
        {CMD_TOP, 4'h1, 8'h80}, {CMD_TOP, 4'h8, 8'h81},
        {CMD_SHUT, 4'h8, 8'h01}, {CMD_INC, 4'h8, 8'h01},
        {CMD_SHUT, 4'h8, 8'h00}, {CMD_SAVE_NV, 4'h0, 8'h01},
        {CMD_SAVE_NV, 4'h1, 8'h01}, {CMD_WR_WIPER, 4'h1, 8'h66},
        {CMD_CTRL, 4'h0, 8'h02}, {CMD_WR_WIPER, 4'h0, 8'h55},
        {CMD_INC, 4'h8, 8'h01}, {CMD_LOAD_PRE, 4'h8, 8'h00},
        {CMD_DBL, 4'h1, 8'h01}, {CMD_RESTORE_NV, 4'h1, 8'h00},
        {CMD_CTRL, 4'h0, 8'h01}, {CMD_WR_WIPER, 4'h1, 8'h77},
        {CMD_SAVE_NV, 4'h1, 8'h01}, {CMD_CTRL, 4'h0, 8'h00},
        {CMD_SAVE_NV, 4'h1, 8'h01}, {CMD_NOP, 4'h0, 8'h00},
        {CMD_RESET, 4'h0, 8'h00}};

    initial begin
        rst = 1'b1;
        gain_mode_strap_pin = 1'b0;
        reset_pin_n = 1'b1;
        boot(1'b0);
        cmd(CMD_WR_WIPER, 4'h0, 8'($random(seed)));
        cmd(CMD_WR_WIPER, 4'h1, 8'($random(seed)));
        foreach (seq[i]) cmd(seq[i][16:12], seq[i][11:8], seq[i][7:0]);
        $display("test sequence done");
        cmd(CMD_WR_WIPER, 4'h0, 8'h00);
        repeat (10) cmd(CMD_DBL, 4'h0, 8'h01);
        repeat (9) cmd(CMD_HALF, 4'h0, 8'h00);
        $display("test shift done");
        cmd(CMD_CTRL, 4'h0, 8'h04);
        repeat (2) @(posedge ref_clk);
        #1;
        cmp8("gain", {7'h0, gain_mode_q}, 8'h01);
        cmd(CMD_WR_WIPER, 4'h4, 8'h21);
        cmd(CMD_WR_WIPER, 4'h5, 8'h42);
        cmd(CMD_INC, 4'hC, 8'h01);
        cmd(CMD_DBL, 4'h4, 8'h01);
        cmd(CMD_CTRL, 4'h0, 8'h00);
        gain_mode_strap_pin = 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        cmp8("strap", {7'h0, gain_mode_q}, 8'h01);
        gain_mode_strap_pin = 1'b0;
        $display("test gain done");
        cmd(CMD_WR_WIPER, 4'h0, 8'h11);
        reset_pin_n = 1'b0;
        for (int n = 0; n < 10 && busy_q !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        reset_pin_n = 1'b1;
        reload(RC - 2);
        note();
        $display("test pin reset done");
        boot(1'b1);
        stop_test();
    end

    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        stop_test();
    end
endmodule // tb
